// ---- bench/safs_host_model.sv ----
// Behavioural register host issuing single byte reads
`timescale 1ns/1ps
module safs_host_model (
  input wire logic core_clk, // Core clock
  input wire logic go, // Start one read
  input wire logic [7:0] addr, // Offset to read
  output logic reg_rd_en, // Read strobe
  output logic [7:0] reg_addr, // Read offset
  input wire logic reg_rd_valid, // Answer valid
  input wire logic [7:0] reg_rd_data, // Answer data
  output logic [7:0] rd_byte, // Captured byte
  output logic rd_done // Capture done pulse
);
  // Idle values at time zero
  initial begin
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    rd_byte = 8'h00;
    rd_done = 1'b0;
  end
  // Idle offset toggles so a stale offset never looks held
  always @(posedge core_clk) begin
    reg_rd_en <= go;
    reg_addr <= go ? addr : ~reg_addr;
    rd_done <= reg_rd_valid;
    if (reg_rd_valid) begin
      rd_byte <= reg_rd_data;
    end
  end
endmodule

// ---- bench/safs_status_assertions.sv ----
// Assertion checker on the status flag block ports
`timescale 1ns/1ps
module safs_status_assertions (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Sync reset
  input wire logic reg_rd_en, // Read strobe
  input wire logic [7:0] reg_addr, // Read offset
  input wire logic [7:0] reg_rd_data, // Read data
  input wire logic reg_rd_valid, // Read valid
  input wire logic bus_power_present, // Present level
  input wire logic power_good_pin, // Power good level
  input wire logic sense_request_bit, // Sense request
  input wire logic supply_status_irq_mask, // Upper mask
  input wire logic attach_detect_irq_mask, // Lower mask
  input wire logic sense_request_clear, // Sense clear pulse
  input wire logic stat_event // Event pulse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [5:0] pr_h, pg_h, rs_h; // Input and reset history
  logic [7:0] addr_q; // Offset seen last cycle
  logic hit; // Status read answered now
  // Shift histories so that stable windows can be judged
  always_ff @(posedge core_clk) begin
    pr_h <= {pr_h[4:0], bus_power_present};
    pg_h <= {pg_h[4:0], power_good_pin};
    rs_h <= {rs_h[4:0], sys_rst};
    addr_q <= reg_addr;
  end
  // Status hit well clear of any reset
  assign hit = reg_rd_valid && addr_q == safs_pkg::STATUS_OFFSET && rs_h == 6'h00;
  property p_rst;
    $fell(sys_rst) |-> reg_rd_data == safs_pkg::STATUS_RESET && !reg_rd_valid && !stat_event;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_present;
    hit && (pr_h[5:1] == 5'h1f || pr_h[5:1] == 5'h00) |-> reg_rd_data[7] == pr_h[1];
  endproperty
  a_present: assert property (p_present) else $error("present bit wrong");
  property p_pgood;
    hit && (pg_h[5:1] == 5'h1f || pg_h[5:1] == 5'h00) |-> reg_rd_data[6] == pg_h[1];
  endproperty
  a_pgood: assert property (p_pgood) else $error("power good bit wrong");
  property p_rsvd;
    reg_rd_valid |-> !reg_rd_data[4];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_valid;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_mask;
    supply_status_irq_mask && attach_detect_irq_mask |=> !stat_event;
  endproperty
  a_mask: assert property (p_mask) else $error("masked event pulsed");
  property p_sns_ev;
    sense_request_clear && !$past(attach_detect_irq_mask) |-> stat_event;
  endproperty
  a_sns_ev: assert property (p_sns_ev) else $error("sense event missing");
  property p_sns_req;
    sense_request_clear |-> $past(sense_request_bit) ##1 !sense_request_clear;
  endproperty
  a_sns_req: assert property (p_sns_req) else $error("sense clear wrong");
endmodule
bind safs_status safs_status_assertions i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .bus_power_present(bus_power_present),
  .power_good_pin(power_good_pin), .sense_request_bit(sense_request_bit),
  .supply_status_irq_mask(supply_status_irq_mask), .attach_detect_irq_mask(attach_detect_irq_mask),
  .sense_request_clear(sense_request_clear), .stat_event(stat_event));

// ---- bench/supply_attach_status_flags_tb_top.sv ----
// Self-checking bench of the supply and attach status flags
`timescale 1ns/1ps
module supply_attach_status_flags_tb_top;
  logic core_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, pres = 1'b0, pgood = 1'b1, vfail = 1'b0; // Drives
  logic c100 = 1'b0, c700 = 1'b0, prb = 1'b0, src = 1'b0, boost = 1'b1, sns = 1'b0; // Analog side
  logic smask = 1'b0, amask = 1'b0; // Event masks
  logic [7:0] haddr = 8'h00, rd_addr, rd_data, hbyte; // Read path
  logic rd_en, rd_valid, hdone, sclr, sev; // Host and block outputs
  int miscompares = 0, samples_checked = 0, ev_cnt = 0; // Counters
  safs_status #(.DISCHARGE_CYCLES(20), .BOOST_WINDOW_CYCLES(40), .PROBE_TICK_CYCLES(2)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_rd_en(rd_en), .reg_addr(rd_addr), .reg_rd_data(rd_data),
    .reg_rd_valid(rd_valid), .bus_power_present(pres), .power_good_pin(pgood), .validation_failed(vfail),
    .bus_100mv_comparator(c100), .bus_700mv_comparator(c700), .probe_request_bit(prb),
    .probe_current_source_en(src), .boost_enable(boost), .sense_request_bit(sns),
    .supply_status_irq_mask(smask), .attach_detect_irq_mask(amask), .sense_request_clear(sclr),
    .stat_event(sev));
  safs_host_model i_host (.core_clk(core_clk), .go(go), .addr(haddr), .reg_rd_en(rd_en),
    .reg_addr(rd_addr), .reg_rd_valid(rd_valid), .reg_rd_data(rd_data), .rd_byte(hbyte), .rd_done(hdone));
  // 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Count event pin pulses
  always @(posedge core_clk) begin
    if (sev === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Ends the run when a bounded wait ran out
  task automatic tmo(input int n);
    if (n >= 20) begin
      miscompares++;
      $display("Error at %0t: wait timed out", $time);
      summarize();
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: events %0d expected %0d", $time, got, exp);
    end
  endtask
  // Expected status byte from current levels and lower field
  function automatic logic [7:0] stat(input logic [3:0] low);
    return {pres, pgood, vfail, 1'b0, low};
  endfunction
  // One read through the host, then compare
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    haddr <= a;
    @(posedge core_clk);
    go <= 1'b0;
    @(negedge core_clk);
    while (hdone !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    tmo(n);
    chk_byte(hbyte, exp);
  endtask
  task automatic rst;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
  endtask
  // Main sequence
  initial begin
    logic [2:0] v, old;
    logic m;
    int n;
    void'($urandom(32'hade3abe7));
    rst();
    rd(8'h07, 8'h40);
    for (int i = 0; i < 16; i++) begin
      v = 3'($urandom);
      m = 1'($urandom);
      old = {pres, pgood, vfail};
      ev_cnt = 0;
      @(posedge core_clk);
      smask <= m;
      {pres, pgood, vfail} <= v;
      cyc(8);
      chk_count(ev_cnt != 0, (v != old) && !m);
      rd(8'h07, stat(4'h0));
      rd(8'h07, stat(4'h0));
    end
    $display("test upper field done");
    @(posedge core_clk);
    {pres, pgood, vfail, smask} <= 4'h4;
    sns <= 1'b1;
    cyc(8);
    rd(8'h07, stat(4'h0));
    ev_cnt = 0;
    @(posedge core_clk);
    c100 <= 1'b1;
    n = 0;
    while (sclr !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    tmo(n);
    @(posedge core_clk);
    sns <= 1'b0;
    // Let the event counter take the last pulse first
    cyc(1);
    chk_count(ev_cnt, 1);
    rd(8'h08, 8'h00);
    rd(8'h07, stat(4'h1));
    rd(8'h07, stat(4'h0));
    $display("test sense done");
    ev_cnt = 0;
    @(posedge core_clk);
    smask <= 1'b1;
    amask <= 1'b1;
    src <= 1'b1;
    cyc(4);
    c700 <= 1'b1;
    cyc(8);
    rd(8'h07, stat(4'h8));
    chk_count(ev_cnt, 0);
    @(posedge core_clk);
    {smask, amask, src, c700} <= 4'h0;
    prb <= 1'b1;
    cyc(30);
    rd(8'h07, stat(4'h4));
    @(posedge core_clk);
    prb <= 1'b0;
    c100 <= 1'b0;
    src <= 1'b1;
    cyc(380);
    rd(8'h07, stat(4'h0));
    cyc(150);
    rd(8'h07, stat(4'h4));
    $display("test probe done");
    @(posedge core_clk);
    src <= 1'b0;
    c100 <= 1'b1;
    cyc(5);
    boost <= 1'b0;
    cyc(10);
    c100 <= 1'b0;
    cyc(8);
    rd(8'h07, stat(4'h2));
    @(posedge core_clk);
    boost <= 1'b1;
    c100 <= 1'b1;
    cyc(5);
    boost <= 1'b0;
    cyc(50);
    rd(8'h07, stat(4'h4));
    $display("test boost done");
    @(posedge core_clk);
    boost <= 1'b1;
    rst();
    rd(8'h07, 8'h40);
    $display("test second reset done");
    summarize();
  end
endmodule

// ---- src/safs_pkg.sv ----
// Constants and types shared by the supply and attach status flag logic
package safs_pkg;

  // Register offset of the status register
  localparam logic [7:0] STATUS_OFFSET = 8'h07;

  // Bit positions inside the status register
  localparam int unsigned PRESENT_BIT = 7; // Bus power present
  localparam int unsigned PGOOD_BIT = 6; // Power good pin level
  localparam int unsigned VALFAIL_BIT = 5; // Validation failed
  localparam int unsigned RSVD_BIT = 4; // Reserved, reads zero
  localparam int unsigned DONE_BIT = 3; // Probe complete
  localparam int unsigned ERR_BIT = 2; // Probe error
  localparam int unsigned LOW_BIT = 1; // Bus low after boost
  localparam int unsigned SNS_BIT = 0; // Sense change

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h40; // Status register after reset
  localparam logic [2:0] SUPPLY_RESET = 3'h2; // Upper field after reset
  localparam logic [3:0] ATTACH_RESET = 4'h0; // Lower field after reset
  localparam logic [7:0] READ_IDLE = 8'h00; // Data for unmapped offsets

  // Clock and time units
  localparam longint unsigned CLK_PERIOD_PS = 64'd4000; // 250 MHz core clock
  localparam longint unsigned PS_PER_MS = 64'd1000000000; // Picoseconds per ms

  // Timing figures in their own units
  localparam longint unsigned DISCHARGE_MS = 64'd32; // Discharge limit
  localparam longint unsigned BOOST_WINDOW_MS = 64'd132; // Window after boost off
  localparam longint unsigned PROBE_WINDOW_MS = 64'd16; // Probe counter span
  localparam longint unsigned PROBE_COUNT_MAX = 64'd255; // Probe counter counts

  // Derived cycle counts, longest times round down
  localparam longint unsigned DISCHARGE_CYCLES = DISCHARGE_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam longint unsigned BOOST_WINDOW_CYCLES = BOOST_WINDOW_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam longint unsigned PROBE_TICK_CYCLES =
    PROBE_WINDOW_MS * PS_PER_MS / (CLK_PERIOD_PS * PROBE_COUNT_MAX);

  // Probe sequence states
  typedef enum logic [1:0] {
    PRB_IDLE = 2'b00,
    PRB_DISCH = 2'b01,
    PRB_SRC = 2'b10
  } safs_probe_e;

endpackage

// ---- src/safs_status.sv ----
// Supply and attach-detect status register with event flags
`timescale 1ns/1ps
module safs_status #(
  parameter int unsigned DISCHARGE_CYCLES = int'(safs_pkg::DISCHARGE_CYCLES), // Discharge limit
  parameter int unsigned BOOST_WINDOW_CYCLES = int'(safs_pkg::BOOST_WINDOW_CYCLES), // Boost window
  parameter int unsigned PROBE_TICK_CYCLES = int'(safs_pkg::PROBE_TICK_CYCLES) // Probe counter tick
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [7:0] reg_addr, // Register offset of the read
  output logic [7:0] reg_rd_data, // Read data, registered
  output logic reg_rd_valid, // Read data valid pulse
  input wire logic bus_power_present, // Bus power detector level, async
  input wire logic power_good_pin, // Power good pin level, async
  input wire logic validation_failed, // Validation failed, core clock
  input wire logic bus_100mv_comparator, // 100 mV comparator, async
  input wire logic bus_700mv_comparator, // 700 mV comparator, async
  input wire logic probe_request_bit, // Probe request control bit
  input wire logic probe_current_source_en, // Probe current source on
  input wire logic boost_enable, // Boost converter enabled
  input wire logic sense_request_bit, // Sense request control bit
  input wire logic supply_status_irq_mask, // Mask for upper field events
  input wire logic attach_detect_irq_mask, // Mask for lower field events
  output logic sense_request_clear, // Pulse that clears sense request
  output logic stat_event // Pulse to the status output pin
);

  // Synchroniser stages for the async inputs
  logic [3:0] sync1_q, sync1_d; // First stage, read only by second
  logic [3:0] sync2_q, sync2_d; // Second stage, safe levels
  logic b700_prev_q, b700_prev_d; // Previous 700 mV level
  logic b100_prev_q, b100_prev_d; // Previous 100 mV level
  logic present_s, pgood_s, b100_s, b700_s; // Synchronised levels

  // Control edge history
  logic prb_req_prev_q, prb_req_prev_d; // Previous probe request
  logic src_prev_q, src_prev_d; // Previous source enable
  logic boost_prev_q, boost_prev_d; // Previous boost enable
  logic sns_req_prev_q, sns_req_prev_d; // Previous sense request

  // Flag and sequence state
  logic [2:0] supply_q, supply_d; // Upper field bits 7:5
  logic [3:0] attach_q, attach_d; // Lower field bits 3:0
  logic [3:0] attach_set; // Lower field set events
  safs_pkg::safs_probe_e prb_q, prb_d; // Probe sequence state
  logic boost_win_q, boost_win_d; // Boost-off window open
  logic sns_armed_q, sns_armed_d; // Sense comparison active
  logic sns_ref_q, sns_ref_d; // Captured 100 mV state
  logic sns_clr_q, sns_clr_d; // Sense request clear pulse
  logic event_q, event_d; // Status pin pulse

  // Read port state
  logic [7:0] rd_data_q, rd_data_d; // Captured read data
  logic rd_valid_q, rd_valid_d; // Read answer pulse
  logic rd_hit; // Read of the status register
  logic [7:0] status_word; // Current register image

  // Edge terms
  logic b700_rise, b100_fall, prb_rise, src_rise, boost_fall, sns_rise;
  logic disch_expire, tick_expire, count_expire, boost_expire; // Timer pulses
  logic enter_src; // Probe counter restart

  // Synchroniser next values
  always_comb begin
    sync1_d = {bus_power_present, power_good_pin, bus_100mv_comparator, bus_700mv_comparator};
    sync2_d = sync1_q;
    b700_prev_d = b700_s;
    b100_prev_d = b100_s;
  end

  // Synchroniser registers, power good idles high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= 4'h4;
      sync2_q <= 4'h4;
      b700_prev_q <= 1'b0;
      b100_prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      b700_prev_q <= b700_prev_d;
      b100_prev_q <= b100_prev_d;
    end
  end

  assign present_s = sync2_q[3];
  assign pgood_s = sync2_q[2];
  assign b100_s = sync2_q[1];
  assign b700_s = sync2_q[0];

  // Edge detection on synchronised and control levels
  assign b700_rise = b700_s && !b700_prev_q;
  assign b100_fall = !b100_s && b100_prev_q;
  assign prb_rise = probe_request_bit && !prb_req_prev_q;
  assign src_rise = probe_current_source_en && !src_prev_q;
  assign boost_fall = !boost_enable && boost_prev_q;
  assign sns_rise = sense_request_bit && !sns_req_prev_q;
  assign enter_src = src_rise;

  // Control history next values
  always_comb begin
    prb_req_prev_d = probe_request_bit;
    src_prev_d = probe_current_source_en;
    boost_prev_d = boost_enable;
    sns_req_prev_d = sense_request_bit;
  end

  // Control history registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prb_req_prev_q <= 1'b0;
      src_prev_q <= 1'b0;
      boost_prev_q <= 1'b0;
      sns_req_prev_q <= 1'b0;
    end else begin
      prb_req_prev_q <= prb_req_prev_d;
      src_prev_q <= src_prev_d;
      boost_prev_q <= boost_prev_d;
      sns_req_prev_q <= sns_req_prev_d;
    end
  end

  // Discharge timeout while the probe drains the bus
  safs_timeout #(.LIMIT(DISCHARGE_CYCLES), .RELOAD(1'b0)) u_disch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(prb_rise && b100_s),
    .run(prb_q == safs_pkg::PRB_DISCH),
    .step(1'b1),
    .expire(disch_expire)
  );

  // Probe counter tick generator, free running in the source phase
  safs_timeout #(.LIMIT(PROBE_TICK_CYCLES), .RELOAD(1'b1)) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(enter_src),
    .run(prb_q == safs_pkg::PRB_SRC),
    .step(1'b1),
    .expire(tick_expire)
  );

  // Probe counter, times out after its full count
  safs_timeout #(.LIMIT(int'(safs_pkg::PROBE_COUNT_MAX)), .RELOAD(1'b0)) u_count (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(enter_src),
    .run(prb_q == safs_pkg::PRB_SRC),
    .step(tick_expire),
    .expire(count_expire)
  );

  // Window timer after the boost converter turns off
  safs_timeout #(.LIMIT(BOOST_WINDOW_CYCLES), .RELOAD(1'b0)) u_boost (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(boost_fall),
    .run(boost_win_q),
    .step(1'b1),
    .expire(boost_expire)
  );

  // Probe sequence and boost window next state
  always_comb begin
    prb_d = prb_q;
    boost_win_d = boost_win_q;
    attach_set = 4'h0;
    if (b700_rise && probe_current_source_en) begin
      attach_set[safs_pkg::DONE_BIT] = 1'b1;
    end
    attach_set[safs_pkg::SNS_BIT] = sns_clr_d;
    unique case (prb_q)
      safs_pkg::PRB_IDLE: begin
        // Drain first when the bus starts above 100 mV
        if (prb_rise && b100_s) begin
          prb_d = safs_pkg::PRB_DISCH;
        end
      end
      safs_pkg::PRB_DISCH: begin
        if (disch_expire) begin
          attach_set[safs_pkg::ERR_BIT] = 1'b1;
          prb_d = safs_pkg::PRB_IDLE;
        end else if (!b100_s) begin
          prb_d = safs_pkg::PRB_IDLE;
        end
      end
      safs_pkg::PRB_SRC: begin
        if (count_expire) begin
          attach_set[safs_pkg::ERR_BIT] = 1'b1;
          prb_d = safs_pkg::PRB_IDLE;
        end else if (b700_rise || !probe_current_source_en) begin
          prb_d = safs_pkg::PRB_IDLE;
        end
      end
      default: begin
        prb_d = safs_pkg::PRB_IDLE;
      end
    endcase
    // Source turning on starts the counted phase
    if (src_rise) begin
      prb_d = safs_pkg::PRB_SRC;
    end
    // Boost window opens on boost turning off
    if (boost_fall) begin
      boost_win_d = 1'b1;
    end else if (boost_enable) begin
      boost_win_d = 1'b0;
    end else if (boost_win_q && boost_expire) begin
      // bus still high at window end
      if (b100_s) begin
        attach_set[safs_pkg::ERR_BIT] = 1'b1;
      end
      boost_win_d = 1'b0;
    end else if (boost_win_q && b100_fall) begin
      attach_set[safs_pkg::LOW_BIT] = 1'b1;
      boost_win_d = 1'b0;
    end
  end

  // Probe and boost window registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prb_q <= safs_pkg::PRB_IDLE;
      boost_win_q <= 1'b0;
    end else begin
      prb_q <= prb_d;
      boost_win_q <= boost_win_d;
    end
  end

  // Sense comparison next state
  always_comb begin
    sns_armed_d = sns_armed_q;
    sns_ref_d = sns_ref_q;
    sns_clr_d = 1'b0;
    if (sns_rise) begin
      sns_ref_d = b100_s;
      sns_armed_d = 1'b1;
    end else if (!sense_request_bit) begin
      sns_armed_d = 1'b0;
    end else if (sns_armed_q && (b100_s != sns_ref_q)) begin
      sns_clr_d = 1'b1;
      sns_armed_d = 1'b0;
    end
  end

  // Sense comparison registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sns_armed_q <= 1'b0;
      sns_ref_q <= 1'b0;
      sns_clr_q <= 1'b0;
    end else begin
      sns_armed_q <= sns_armed_d;
      sns_ref_q <= sns_ref_d;
      sns_clr_q <= sns_clr_d;
    end
  end

  // Register image from current flags
  always_comb begin
    status_word = 8'h00;
    status_word[safs_pkg::PRESENT_BIT] = supply_q[2];
    status_word[safs_pkg::PGOOD_BIT] = supply_q[1];
    status_word[safs_pkg::VALFAIL_BIT] = supply_q[0];
    status_word[safs_pkg::RSVD_BIT] = 1'b0;
    status_word[3:0] = attach_q;
  end

  assign rd_hit = reg_rd_en && (reg_addr == safs_pkg::STATUS_OFFSET);

  // Flags, read data and status pulse next values
  always_comb begin
    supply_d = {present_s, pgood_s, validation_failed};
    attach_d = (attach_q & ~{4{rd_hit}}) | attach_set;
    rd_data_d = rd_hit ? status_word : safs_pkg::READ_IDLE;
    rd_valid_d = reg_rd_en;
    event_d = ((supply_d != supply_q) && !supply_status_irq_mask) ||
              ((attach_set != 4'h0) && !attach_detect_irq_mask);
  end

  // Flag and read registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      supply_q <= safs_pkg::SUPPLY_RESET;
      attach_q <= safs_pkg::ATTACH_RESET;
      rd_data_q <= safs_pkg::STATUS_RESET;
      rd_valid_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      supply_q <= supply_d;
      attach_q <= attach_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      event_q <= event_d;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign reg_rd_valid = rd_valid_q;
  assign sense_request_clear = sns_clr_q;
  assign stat_event = event_q;

endmodule

// ---- src/safs_timeout.sv ----
// Restartable step counter that flags a timeout after a set number of steps
`timescale 1ns/1ps
module safs_timeout #(
  parameter int unsigned LIMIT = 4, // Steps until timeout
  parameter bit RELOAD = 1'b0 // Rearm after each timeout
) (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic restart, // Clear count and arm
  input wire logic run, // Counting allowed
  input wire logic step, // Count one step
  output logic expire // One-cycle timeout pulse
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1); // Final count value
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] count_q, count_d; // Steps taken
  logic armed_q, armed_d; // Counter active
  logic expire_q, expire_d; // Timeout pulse register

  // Next count, arm and pulse
  always_comb begin
    count_d = count_q;
    armed_d = armed_q;
    expire_d = 1'b0;
    if (restart) begin
      // Restart wins over counting
      count_d = '0;
      armed_d = 1'b1;
    end else if (armed_q && run && step) begin
      if (count_q == LAST) begin
        count_d = '0;
        armed_d = RELOAD;
        expire_d = 1'b1;
      end else begin
        count_d = count_q + ONE;
      end
    end
  end

  // Register the counter state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= '0;
      armed_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      count_q <= count_d;
      armed_q <= armed_d;
      expire_q <= expire_d;
    end
  end

  assign expire = expire_q;

endmodule
